// *** verilog/adc_ctrl_pkg.sv ***
// Constants, types and register map of the converter selection and sequencing logic
// What this block does
// - Buffered selection copies through while not converting
// - Active selection frozen once conversion begins
// - Copying resumes in final converter cycle
// - Start bit begins conversion on next tick
// - Free-run reselection applies one conversion later
// - Overrange input yields full-scale code
// - Halt in idle/noise sleep starts conversion
// - Sleep conversion completion always raises interrupt
// - Other sleep modes leave converter enabled
// - Code is input times 1024 over reference
// - Result readable when done flag sets
// - Reference select decodes pin, supply, internal
// - Channel select decodes pins, bandgap, ground
package adc_ctrl_pkg;

    // ==========================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_SEL = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_RES_LOW = 8'h08;
    localparam logic [7:0] OFF_RES_HIGH = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;

    // ==========================================================
    // Field positions
    localparam int SEL_REF_LO = 6;
    localparam int SEL_ADJ = 5;
    localparam int CTRL_ENABLE = 7;
    localparam int CTRL_START = 6;
    localparam int CTRL_FREE_RUN = 5;
    localparam int CTRL_DONE = 4;
    localparam int CTRL_INT_EN = 3;
    localparam int STAT_DONE = 0;
    localparam int STAT_SLEEP = 1;
    localparam int STAT_W = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // ==========================================================
    // Conversion timing in converter clock cycles
    localparam logic [4:0] CYC_NORMAL = 5'h0d;
    localparam logic [4:0] CYC_EXT = 5'h19;
    localparam logic [4:0] LAST_NORMAL = CYC_NORMAL - 5'h01;
    localparam logic [4:0] LAST_EXT = CYC_EXT - 5'h01;
    localparam logic [4:0] SH_NORMAL = 5'h01;
    localparam logic [4:0] SH_EXT = 5'h0d;

    // ==========================================================
    // Result coding
    localparam int RES_W = 10;
    localparam logic [9:0] PROBE_MSB = 10'h200;

    // ==========================================================
    // Selection codes
    localparam logic [1:0] REF_PIN = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_RESERVED = 2'h2;
    localparam logic [1:0] REF_INTERNAL = 2'h3;
    localparam logic [3:0] CH_PIN_MAX = 4'h7;
    localparam logic [3:0] CH_BANDGAP = 4'he;
    localparam logic [3:0] CH_GROUND = 4'hf;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        SLP_IDLE = 3'h0,
        SLP_NOISE = 3'h1,
        SLP_POWER_DOWN = 3'h2,
        SLP_POWER_SAVE = 3'h3,
        SLP_STANDBY = 3'h6
    } sleep_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_CONVERT = 2'b11
    } conv_state_t;

    typedef struct packed {
        logic [1:0] reference;
        logic [3:0] channel;
    } selection_t;

    typedef struct packed {
        logic [7:0] pin_enable;
        logic bandgap;
        logic ground;
        logic ref_supply;
        logic ref_internal;
    } analog_route_t;

endpackage : adc_ctrl_pkg

// *** verilog/conv_clock_divider.sv ***
`timescale 1ns/10ps
// Converter clock tick generator from the system clock
module conv_clock_divider #(
    parameter int PS_W = 3,
    parameter int CNT_W = 7
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run,
    input wire logic [PS_W-1:0] prescale,
    output logic tick
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] last;

    // Codes 0 and 1 both divide by two
    always_comb begin
        if (prescale == '0) begin
            last = CNT_W'(1);
        end else begin
            last = (CNT_W'(1) << prescale) - CNT_W'(1);
        end
    end

    // Held in reset while the converter is off, so the first tick is a full period away
    always_ff @(posedge clk_sys) begin
        if (rst || !run) begin
            count <= '0;
            tick <= 1'b0;
        end else if (count >= last) begin
            count <= '0;
            tick <= 1'b1;
        end else begin
            count <= count + CNT_W'(1);
            tick <= 1'b0;
        end
    end
endmodule : conv_clock_divider

// *** verilog/adc_sel_ctrl.sv ***
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
// Converter selection buffering, conversion sequencing, interrupts and APB registers
module adc_sel_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_halted,
    input wire adc_ctrl_pkg::sleep_mode_t sleep_mode,
    input wire logic comp_above,
    output adc_ctrl_pkg::selection_t active_sel,
    output adc_ctrl_pkg::analog_route_t route,
    output logic analog_enable,
    output logic sample_hold,
    output logic [9:0] trial_code,
    output logic irq
);
    import adc_ctrl_pkg::*;

    // ==========================================================
    // Declarations
    selection_t temp_sel;
    logic left_adjust;
    logic start;
    logic free_run;
    logic done;
    logic sleep_done;
    logic [2:0] prescale;
    logic [STAT_W-1:0] mask;
    conv_state_t state;
    logic [4:0] cycle;
    logic extended;
    logic first_pending;
    logic from_sleep;
    logic [RES_W-1:0] code;
    logic [RES_W-1:0] probe;
    logic [RES_W-1:0] result;
    logic read_block;
    logic halted_prev;
    logic tick;
    logic access;
    logic wr;
    logic rd;
    logic [7:0] wbyte;
    logic wr_sel;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic start_req;
    logic sleep_go;
    logic [4:0] last_cyc;
    logic [4:0] sh_cyc;
    logic finish;
    logic locked;
    logic mapped;
    logic [7:0] read_word;

    // ==========================================================
    // Converter clock
    conv_clock_divider #(
        .PS_W(3),
        .CNT_W(7)
    ) u_divider (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(analog_enable),
        .prescale(prescale),
        .tick(tick)
    );

    // ==========================================================
    // APB decode; one wait state so read data come from a register
    always_comb begin
        access = psel & penable & pready;
        wr = access & pwrite;
        rd = access & ~pwrite;
        wbyte = pwdata[7:0];
        wr_sel = wr && (paddr == OFF_SEL);
        wr_ctrl = wr && (paddr == OFF_CTRL);
        wr_status = wr && (paddr == OFF_STATUS);
        wr_mask = wr && (paddr == OFF_MASK);
    end

    // Address map check; result registers accept and ignore writes
    always_comb begin
        unique case (paddr)
            OFF_SEL, OFF_CTRL, OFF_RES_LOW, OFF_RES_HIGH, OFF_STATUS, OFF_MASK: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Read multiplexer; adjustment applies at read time, so it acts at once
    always_comb begin
        unique case (paddr)
            OFF_SEL: begin
                read_word = {temp_sel.reference, left_adjust, 1'b0, temp_sel.channel};
            end
            OFF_CTRL: begin
                read_word = {analog_enable, start, free_run, done, mask[STAT_DONE], prescale};
            end
            OFF_RES_LOW: begin
                read_word = left_adjust ? {result[1:0], 6'h00} : result[7:0];
            end
            OFF_RES_HIGH: begin
                read_word = left_adjust ? result[9:2] : {6'h00, result[9:8]};
            end
            OFF_STATUS: begin
                read_word = {6'h00, sleep_done, done};
            end
            OFF_MASK: begin
                read_word = {6'h00, mask};
            end
            default: begin
                read_word = 8'h00;
            end
        endcase
    end

    // Ready pulses one cycle after the access phase opens
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    // Read data and error captured in the wait cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata <= {24'h00_0000, read_word};
            pslverr <= ~mapped;
        end else if (access) begin
            pslverr <= 1'b0;
        end
    end

    // ==========================================================
    // Sequencing terms
    always_comb begin
        last_cyc = extended ? LAST_EXT : LAST_NORMAL;
        sh_cyc = extended ? SH_EXT : SH_NORMAL;
        finish = (state == ST_CONVERT) && tick && (cycle == last_cyc);
        // The lock opens in the last cycle, before the done flag rises
        locked = (state == ST_CONVERT) && (cycle != last_cyc);
        start_req = wr_ctrl && wbyte[CTRL_START] && wbyte[CTRL_ENABLE];
    end

    // Halt in an eligible sleep mode; only entry into the halt counts
    always_comb begin
        sleep_go = cpu_halted && !halted_prev && analog_enable
            && ((sleep_mode == SLP_IDLE) || (sleep_mode == SLP_NOISE))
            && (state == ST_IDLE) && !free_run && mask[STAT_DONE];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            halted_prev <= 1'b0;
        end else begin
            halted_prev <= cpu_halted;
        end
    end

    // ==========================================================
    // Selection buffer written by software
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            temp_sel <= selection_t'(SEL_RESET[5:0]);
            left_adjust <= SEL_RESET[SEL_ADJ];
        end else if (wr_sel) begin
            temp_sel.reference <= wbyte[SEL_REF_LO+1:SEL_REF_LO];
            temp_sel.channel <= wbyte[3:0];
            left_adjust <= wbyte[SEL_ADJ];
        end
    end

    // Decode of a selection into analog switch controls
    function automatic analog_route_t decode_route(input selection_t s);
        analog_route_t r;
        r = '0;
        if (s.channel <= CH_PIN_MAX) begin
            r.pin_enable = 8'h01 << s.channel[2:0];
        end else if (s.channel == CH_BANDGAP) begin
            r.bandgap = 1'b1;
        end else begin
            // Unused codes park on ground rather than float
            r.ground = 1'b1;
        end
        r.ref_supply = (s.reference == REF_SUPPLY);
        // Reserved code leaves only the pin, so no source fights it
        r.ref_internal = (s.reference == REF_INTERNAL);
        return r;
    endfunction : decode_route

    // Active selection follows the buffer whenever the lock is open
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            active_sel <= selection_t'(SEL_RESET[5:0]);
            route <= decode_route(selection_t'(SEL_RESET[5:0]));
        end else if (!locked) begin
            active_sel <= temp_sel;
            route <= decode_route(temp_sel);
        end
    end

    // ==========================================================
    // Control bits; sleep never touches the enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            analog_enable <= 1'b0;
            free_run <= 1'b0;
            prescale <= PRESCALE_RESET;
        end else if (wr_ctrl) begin
            analog_enable <= wbyte[CTRL_ENABLE];
            free_run <= wbyte[CTRL_FREE_RUN];
            prescale <= wbyte[2:0];
        end
    end

    // Mask; the interrupt enable in control is the done bit of the mask
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask <= MASK_RESET;
        end else if (wr_mask) begin
            mask <= wbyte[STAT_W-1:0];
        end else if (wr_ctrl) begin
            mask[STAT_DONE] <= wbyte[CTRL_INT_EN];
        end
    end

    // Start bit reads one while a conversion is pending or running
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start <= 1'b0;
        end else if (!analog_enable && !start_req) begin
            start <= 1'b0;
        end else if (start_req || sleep_go) begin
            start <= 1'b1;
        end else if (finish && !free_run) begin
            start <= 1'b0;
        end
    end

    // First conversion after enabling runs the extended length
    always_ff @(posedge clk_sys) begin
        if (rst || !analog_enable) begin
            first_pending <= 1'b1;
        end else if (state == ST_ARMED && tick) begin
            first_pending <= 1'b0;
        end
    end

    // ==========================================================
    // Conversion state machine; disabling aborts at once
    always_ff @(posedge clk_sys) begin
        if (rst || (!analog_enable && !start_req)) begin
            state <= ST_IDLE;
            cycle <= 5'h00;
            extended <= 1'b0;
            from_sleep <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_req || sleep_go) begin
                        state <= ST_ARMED;
                        from_sleep <= sleep_go;
                    end
                end
                ST_ARMED: begin
                    if (tick) begin
                        state <= ST_CONVERT;
                        cycle <= 5'h00;
                        extended <= first_pending;
                    end
                end
                ST_CONVERT: begin
                    if (finish) begin
                        cycle <= 5'h00;
                        extended <= 1'b0;
                        from_sleep <= 1'b0;
                        // Free running restarts with the selection copied just now
                        state <= free_run ? ST_CONVERT : ST_IDLE;
                    end else if (tick) begin
                        cycle <= cycle + 5'h01;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Successive approximation; comparator is on this clock
    always_ff @(posedge clk_sys) begin
        if (rst || state != ST_CONVERT) begin
            code <= '0;
            probe <= '0;
        end else if (finish) begin
            code <= '0;
            probe <= '0;
        end else if (tick && cycle == sh_cyc) begin
            probe <= PROBE_MSB;
        end else if (tick && probe != '0) begin
            // Input above every trial level keeps every bit: full scale
            code <= comp_above ? (code | probe) : code;
            probe <= probe >> 1;
        end
    end

    // Analog-facing outputs, registered
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sample_hold <= 1'b0;
            trial_code <= '0;
        end else begin
            sample_hold <= (state == ST_CONVERT) && (cycle <= sh_cyc);
            trial_code <= code | probe;
        end
    end

    // ==========================================================
    // Result: low read blocks updates until high is read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result <= '0;
        end else if (finish && !read_block) begin
            result <= code;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            read_block <= 1'b0;
        end else if (rd && paddr == OFF_RES_HIGH) begin
            read_block <= 1'b0;
        end else if (rd && paddr == OFF_RES_LOW) begin
            read_block <= 1'b1;
        end
    end

    // ==========================================================
    // Sticky flags, write one to clear; a completion in the clear cycle wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done <= 1'b0;
        end else if (finish) begin
            done <= 1'b1;
        end else if ((wr_ctrl && wbyte[CTRL_DONE]) || (wr_status && wbyte[STAT_DONE])) begin
            done <= 1'b0;
        end
    end

    // Marks a completion that was started by a halt
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sleep_done <= 1'b0;
        end else if (finish && from_sleep) begin
            sleep_done <= 1'b1;
        end else if (wr_status && wbyte[STAT_SLEEP]) begin
            sleep_done <= 1'b0;
        end
    end

    // Level interrupt; also serves as the wake request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |({sleep_done, done} & mask);
        end
    end

endmodule : adc_sel_ctrl

// *** tb/adc_sel_ctrl_properties.sv ***
// Port-level checks of the converter control block
`timescale 1ns/10ps
module adc_sel_ctrl_properties (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_halted,
    input wire adc_ctrl_pkg::selection_t active_sel,
    input wire adc_ctrl_pkg::analog_route_t route,
    input wire logic analog_enable,
    input wire logic sample_hold
);
    import adc_ctrl_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ==========================================================
    // Sampling window, halt and enable, APB wait state and route decode
    sequence s_hold;
        sample_hold [*4];
    endsequence
    sequence s_wait;
        !pready ##1 pready;
    endsequence
    property p_lock;
        sample_hold && $past(sample_hold) |-> $stable(active_sel);
    endproperty
    a_lock: assert property (p_lock) else $error("selection moved while sampling");
    // Abort by clearing enable may cut the window short
    property p_sh_len;
        disable iff (rst || !analog_enable) $rose(sample_hold) |-> s_hold;
    endproperty
    a_sh_len: assert property (p_sh_len) else $error("sampling window too short");
    property p_en;
        $rose(sample_hold) |-> $past(analog_enable);
    endproperty
    a_en: assert property (p_en) else $error("conversion while disabled");
    property p_keep;
        $rose(cpu_halted) && !psel |=> $stable(analog_enable);
    endproperty
    a_keep: assert property (p_keep) else $error("halt changed enable");
    property p_wait;
        $rose(penable) && psel |-> s_wait;
    endproperty
    a_wait: assert property (p_wait) else $error("answer not after one wait");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than a cycle");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_ch;
        route.pin_enable == ((active_sel.channel <= CH_PIN_MAX) ?
            (8'h01 << active_sel.channel[2:0]) : 8'h00)
        && route.bandgap == (active_sel.channel == CH_BANDGAP)
        && route.ground == (active_sel.channel > CH_PIN_MAX
            && active_sel.channel != CH_BANDGAP);
    endproperty
    a_ch: assert property (p_ch) else $error("channel decode wrong");
    property p_ref;
        route.ref_supply == (active_sel.reference == REF_SUPPLY)
        && route.ref_internal == (active_sel.reference == REF_INTERNAL);
    endproperty
    a_ref: assert property (p_ref) else $error("reference decode wrong");
endmodule : adc_sel_ctrl_properties

bind adc_sel_ctrl adc_sel_ctrl_properties u_props (
    .clk_sys(clk_sys),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .pslverr(pslverr),
    .cpu_halted(cpu_halted),
    .active_sel(active_sel),
    .route(route),
    .analog_enable(analog_enable),
    .sample_hold(sample_hold)
);

// *** tb/analog_front_model.sv ***
// Behavioural input mux, references and comparator
`timescale 1ns/10ps
module analog_front_model #(
    parameter int PIN_REF_MV = 3000,
    parameter int SUPPLY_MV = 3300
) (
    input wire adc_ctrl_pkg::analog_route_t route,
    input wire logic [9:0] trial_code,
    input wire logic [11:0] pin_mv [8],
    output logic comp_above
);
    import adc_ctrl_pkg::*;
    int vin;
    int vref;
    // Mux follows the decode; ground and unused codes give 0 mV
    always_comb begin
        vin = 0;
        for (int i = 0; i < 8; i++) begin
            if (route.pin_enable[i]) begin
                vin = int'(pin_mv[i]);
            end
        end
        if (route.bandgap) begin
            vin = 1300;
        end
        vref = route.ref_supply ? SUPPLY_MV : (route.ref_internal ? 2560 : PIN_REF_MV);
        // Overrange input stays above every level
        comp_above = (vin * 1024) >= (int'(trial_code) * vref);
    end
endmodule : analog_front_model

// *** tb/adc_selection_and_sleep_conversion_tb.sv ***
// Self-checking bench of the converter control block
`timescale 1ns/10ps
module adc_selection_and_sleep_conversion_tb;
    import adc_ctrl_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic cpu_halted = 1'b0;
    sleep_mode_t sleep_mode = SLP_IDLE;
    logic [31:0] prdata;
    logic pready, pslverr, comp_above, analog_enable, sample_hold, irq, err;
    selection_t active_sel;
    analog_route_t route;
    logic [9:0] trial_code;
    logic [11:0] pin_mv [8] = '{12'h1f4, 12'h3e8, 12'h5dc, 12'h7d0,
        12'h9c4, 12'hb54, 12'h064, 12'hc80};
    logic [1:0] rr [4] = '{REF_SUPPLY, REF_INTERNAL, REF_INTERNAL, REF_PIN};
    logic [3:0] cc [4] = '{4'h1, 4'h7, CH_BANDGAP, CH_GROUND};
    logic [31:0] rd;
    int fail_count = 0;
    int n_checks = 0;
    always #5 clk_sys = ~clk_sys;
    adc_sel_ctrl u_dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_halted(cpu_halted),
        .sleep_mode(sleep_mode), .comp_above(comp_above), .active_sel(active_sel),
        .route(route), .analog_enable(analog_enable), .sample_hold(sample_hold),
        .trial_code(trial_code), .irq(irq)
    );
    analog_front_model u_front (
        .route(route), .trial_code(trial_code), .pin_mv(pin_mv), .comp_above(comp_above)
    );
    // ==========================================================
    // APB master: held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [31:0] sel(input logic [1:0] r, input logic [3:0] c);
        return {24'h0, r, 2'b00, c};
    endfunction : sel
    // Ideal code, clamped at full scale
    function automatic logic [9:0] expc(input logic [1:0] r, input logic [3:0] c);
        int v;
        int vr;
        v = (c <= CH_PIN_MAX) ? int'(pin_mv[c[2:0]]) : ((c == CH_BANDGAP) ? 1300 : 0);
        vr = (r == REF_SUPPLY) ? 3300 : ((r == REF_INTERNAL) ? 2560 : 3000);
        v = v * 1024 / vr;
        return (v > 1023) ? 10'h3ff : v[9:0];
    endfunction : expc
    // Poll status; a stuck flag shows in the result check
    task automatic wait_done();
        rd = 32'h0;
        for (int i = 0; i < 100 && rd[STAT_DONE] !== 1'b1; i++) begin
            apb(1'b0, OFF_STATUS, 32'h0);
        end
    endtask : wait_done
    // Low byte first so both halves come from one conversion
    task automatic chk_res(input logic [9:0] e);
        logic [7:0] lo;
        apb(1'b0, OFF_RES_LOW, 32'h0);
        lo = rd[7:0];
        apb(1'b0, OFF_RES_HIGH, 32'h0);
        chk("result", {22'h0, e}, {22'h0, rd[1:0], lo});
    endtask : chk_res
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    // ==========================================================
    // Test sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        for (int a = 0; a < 28; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            chk("reset read", {31'h0, a == 24}, {rd[30:0], err});
        end
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, OFF_SEL, sel(i[1:0], i[3:0]));
            repeat (2) @(posedge clk_sys);
            chk("active_sel", {26'h0, i[1:0], i[3:0]}, {26'h0, active_sel});
        end
        $display("test select done");
        apb(1'b1, OFF_SEL, sel(REF_SUPPLY, 4'h3));
        apb(1'b1, OFF_CTRL, 32'hc8);
        repeat (4) @(posedge clk_sys);
        apb(1'b1, OFF_SEL, sel(REF_SUPPLY, 4'h5));
        repeat (2) @(posedge clk_sys);
        chk("locked", {26'h0, REF_SUPPLY, 4'h3}, {26'h0, active_sel});
        wait_done();
        chk_res(expc(REF_SUPPLY, 4'h3));
        chk("next sel", {26'h0, REF_SUPPLY, 4'h5}, {26'h0, active_sel});
        chk("irq set", 32'h1, {31'h0, irq});
        apb(1'b1, OFF_MASK, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, OFF_MASK, 32'h1);
        apb(1'b1, OFF_STATUS, 32'h3);
        repeat (2) @(posedge clk_sys);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test lock done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_SEL, sel(rr[i], cc[i]));
            apb(1'b1, OFF_CTRL, 32'hc8);
            wait_done();
            chk_res(expc(rr[i], cc[i]));
            apb(1'b1, OFF_STATUS, 32'h3);
        end
        $display("test codes done");
        apb(1'b1, OFF_SEL, sel(REF_SUPPLY, 4'h2));
        apb(1'b1, OFF_CTRL, 32'he8);
        wait_done();
        apb(1'b1, OFF_SEL, sel(REF_SUPPLY, 4'h4));
        apb(1'b1, OFF_STATUS, 32'h3);
        wait_done();
        chk_res(expc(REF_SUPPLY, 4'h2));
        apb(1'b1, OFF_STATUS, 32'h3);
        wait_done();
        chk_res(expc(REF_SUPPLY, 4'h4));
        apb(1'b1, OFF_CTRL, 32'h08);
        apb(1'b1, OFF_STATUS, 32'h3);
        $display("test free run done");
        apb(1'b1, OFF_SEL, sel(REF_INTERNAL, CH_BANDGAP));
        apb(1'b1, OFF_CTRL, 32'h88);
        // Second pass wakes early, as another interrupt would
        for (int m = 0; m < 2; m++) begin
            sleep_mode <= m ? SLP_IDLE : SLP_NOISE;
            cpu_halted <= 1'b1;
            repeat (8) @(posedge clk_sys);
            cpu_halted <= (m == 0);
            for (int i = 0; i < 200 && irq !== 1'b1; i++) begin
                @(posedge clk_sys);
            end
            apb(1'b0, OFF_STATUS, 32'h0);
            chk("sleep status", 32'h3, rd);
            chk_res(expc(REF_INTERNAL, CH_BANDGAP));
            cpu_halted <= 1'b0;
            apb(1'b1, OFF_STATUS, 32'h3);
        end
        sleep_mode <= SLP_POWER_DOWN;
        cpu_halted <= 1'b1;
        repeat (60) @(posedge clk_sys);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status and enable", 32'h1, {rd[30:0], analog_enable});
        $display("test sleep done");
        stop_test();
    end
    // Whole run is about a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        $display("[ERR] watchdog expected end seen hang");
        stop_test();
    end
endmodule : adc_selection_and_sleep_conversion_tb
